// ---- inc/stcsr_pkg.sv ----
// package: register numbers, field positions and layouts of the supervisor trap control block
package stcsr_pkg;
   // control-register numbers, standard supervisor encodings
   localparam logic [11:0] STCSR_IE_NUM   = 12'h104;
   localparam logic [11:0] STCSR_CEN_NUM  = 12'h106;
   localparam logic [11:0] STCSR_SCR_NUM  = 12'h140;
   localparam logic [11:0] STCSR_EPC_NUM  = 12'h141;
   localparam logic [11:0] STCSR_CAU_NUM  = 12'h142;
   localparam logic [11:0] STCSR_IP_NUM   = 12'h144;
   // interrupt bit positions, equal to the interrupt cause numbers
   localparam int STCSR_SSI_BIT  = 1;
   localparam int STCSR_STI_BIT  = 5;
   localparam int STCSR_SEI_BIT  = 9;
   localparam int STCSR_COF_BIT  = 13;
   localparam int STCSR_MSI_BIT  = 3;
   localparam int STCSR_MTI_BIT  = 7;
   localparam int STCSR_MEI_BIT  = 11;
   localparam int STCSR_STD_BITS = 16;
   // cause code field width (at least bits 4..0)
   localparam int STCSR_CODE_W   = 5;
   // counter-enable positions
   localparam int STCSR_CEN_CY   = 0;
   localparam int STCSR_CEN_TM   = 1;
   localparam int STCSR_CEN_IR   = 2;
   localparam int STCSR_CEN_W    = 32;
   // reset values
   localparam logic [63:0] STCSR_WORD_RST = 64'h0;
   localparam logic [31:0] STCSR_CEN_RST  = 32'h0;
   // counter access check, one request per cycle
   typedef struct packed {
      logic       valid;
      logic [4:0] counter;
      logic       user_mode;
   } stcsr_cnt_req_t;
   // trap entry request from the pipeline
   typedef struct packed {
      logic                      valid;
      logic                      is_irq;
      logic [STCSR_CODE_W-1:0]   code;
      logic [63:0]               pc;
   } stcsr_trap_t;
endpackage : stcsr_pkg

// ---- hw/stcsr_top.sv ----
// design: supervisor trap and interrupt control registers of one hart
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - external pending bit is read-only to software
// - timer pending bit is read-only to software
// - software pending writable; controller may set it
// - overflow pending reflects flags; absent reads zero
// - unimplemented interrupt bits read zero, ignore writes
// - writing ones to enables reveals implemented set
// - pending and enable alias machine-level fields
// - bits 3, 7, 11 read zero
// - priority external, software, timer, counter overflow
// - timer scheduling from real-time counter provided
// - counter-enable register is 32 bits, always present
// - clear enable bit traps user counter read
// - counter-enable bits may be hard-wired zero
// - user access needs supervisor and machine bits
// - scratch is plain full-width read/write
// - exception pc bit 0 always reads zero
// - 32-bit alignment masks pc bit 1 on reads
// - exception pc holds every valid address
// - trap entry writes exception pc only then
// - trap entry writes cause with interrupt flag
// - cause code holds at least values 0..31
// - cause number i maps to bit i
// - interrupt taken when pending, enabled, mode allows
// - writable pending bit cleared by writing zero
module stcsr_top
   import stcsr_pkg::*;
#(
   parameter int          XLEN      = 64,
   parameter bit          HAS_SEI   = 1'b1,
   parameter bit          HAS_STI   = 1'b1,
   parameter bit          HAS_SSI   = 1'b1,
   parameter bit          HAS_COF   = 1'b1,
   parameter bit          ALIGN_SW  = 1'b1,  // alignment switchable 16/32
   parameter bit          ALIGN_32  = 1'b0,  // only 32-bit alignment
   parameter logic [31:0] CEN_IMPL  = 32'hffff_ffff,
   parameter int          N_EVT     = 29
) (
   // clock and reset
   input  wire logic                  CLK_I,
   input  wire logic                  NRST_I,
   // control-register port
   input  wire logic                  CSR_WE_I,
   input  wire logic [11:0]           CSR_NUM_I,
   input  wire logic [XLEN-1:0]       CSR_WDATA_I,
   output logic      [XLEN-1:0]       CSR_RDATA_O,
   output logic                       CSR_HIT_O,
   // interrupt sources from the platform
   input  wire logic                  EXT_IRQ_I,
   input  wire logic                  TIMER_IRQ_I,
   input  wire logic                  SOFT_SET_I,
   input  wire logic [N_EVT-1:0]      EVT_OVF_I,
   // real-time counter and compare value for timer scheduling
   input  wire logic [63:0]           RT_COUNT_I,
   input  wire logic [63:0]           RT_COMPARE_I,
   output logic                       RT_DUE_O,
   // hart state
   input  wire logic                  SUP_MODE_I,
   input  wire logic                  USER_MODE_I,
   input  wire logic                  SUP_GIE_I,
   input  wire logic                  ALIGN32_NOW_I,
   // trap entry and counter check
   input  wire stcsr_trap_t           TRAP_I,
   input  wire stcsr_cnt_req_t        CNT_REQ_I,
   input  wire logic [31:0]           M_CEN_I,
   output logic                       CNT_ILLEGAL_O,
   // interrupt request to the pipeline
   output logic                       IRQ_TAKE_O,
   output logic [STCSR_CODE_W-1:0]    IRQ_CODE_O,
   output logic [XLEN-1:0]            EPC_RET_O,
   // machine-level view of the aliased fields
   output logic [STCSR_STD_BITS-1:0]  M_IP_O,
   output logic [STCSR_STD_BITS-1:0]  M_IE_O
);
   // how the ports behave
   // register port: a write lands on the rising edge with CSR_WE_I high;
   // the new value is visible from the next cycle on
   // read data is combinational from the stored state and inputs for CSR_NUM_I;
   // an unmapped number reads zero and drops CSR_HIT_O
   // back-to-back writes are fine, there is no wait state
   // the whole word is written at once, there are no byte lanes
   // trap entry: TRAP_I.valid high for one cycle; pc and cause land on that edge
   // a trap in the same cycle as a software write of pc or cause wins
   // pending sources are levels, except the software set and the overflow flags, which may pulse
   // a platform set beats a software clear in the same cycle, so no request is lost
   // interrupt take and code are combinational from stored state and inputs;
   // the pipeline decides when to act on them
   // the counter check is combinational and answers in the request's cycle
   // limitation: the compare match is one cycle late, as it is registered
   // to keep the 64-bit compare off the interrupt path
   // limitation: no conversion of invalid addresses; the pc keeps every bit
   // but bit 0, which is cheaper than a legality check per write
   // the machine-level positions 3, 7 and 11 are never delegated here

   localparam logic [STCSR_STD_BITS-1:0] IMPL_MASK =
      (STCSR_STD_BITS'(HAS_SSI) << STCSR_SSI_BIT) | (STCSR_STD_BITS'(HAS_STI) << STCSR_STI_BIT) |
      (STCSR_STD_BITS'(HAS_SEI) << STCSR_SEI_BIT) | (STCSR_STD_BITS'(HAS_COF) << STCSR_COF_BIT);
   localparam logic [STCSR_STD_BITS-1:0] SW_WR_MASK =
      (STCSR_STD_BITS'(HAS_SSI) << STCSR_SSI_BIT) | (STCSR_STD_BITS'(HAS_COF) << STCSR_COF_BIT);

   // state
   logic [STCSR_STD_BITS-1:0] ie_r;
   logic                      sup_software_pending_r;
   logic                      cof_r;
   logic [STCSR_CEN_W-1:0]    cen_r;
   logic [XLEN-1:0]           scr_r;
   logic [XLEN-1:0]           epc_r;
   logic                      cause_irq_r;
   logic [STCSR_CODE_W-1:0]   cause_code_r;
   logic                      rt_due_r;

   // decode of the control-register number
   wire sel_ip  = (CSR_NUM_I == STCSR_IP_NUM);
   wire sel_ie  = (CSR_NUM_I == STCSR_IE_NUM);
   wire sel_cen = (CSR_NUM_I == STCSR_CEN_NUM);
   wire sel_scr = (CSR_NUM_I == STCSR_SCR_NUM);
   wire sel_epc = (CSR_NUM_I == STCSR_EPC_NUM);
   wire sel_cau = (CSR_NUM_I == STCSR_CAU_NUM);
   wire wr_ip   = CSR_WE_I && sel_ip;
   wire wr_ie   = CSR_WE_I && sel_ie;
   wire [STCSR_STD_BITS-1:0] wdat16 = CSR_WDATA_I[STCSR_STD_BITS-1:0];

   // timer scheduling against the real-time counter; compare is written by the platform
   wire rt_due_nxt = (RT_COUNT_I >= RT_COMPARE_I);

   // pending view: external bit comes straight from the platform, timer bit from the platform or the registered compare match
   logic [STCSR_STD_BITS-1:0] ip_view;
   always_comb begin
      ip_view = '0;
      ip_view[STCSR_SEI_BIT] = HAS_SEI && EXT_IRQ_I;
      ip_view[STCSR_STI_BIT] = HAS_STI && (TIMER_IRQ_I || rt_due_r);
      ip_view[STCSR_SSI_BIT] = HAS_SSI && sup_software_pending_r;
      ip_view[STCSR_COF_BIT] = HAS_COF && cof_r;
      // machine-level positions 3, 7, 11 are not delegated here and stay zero
   end

   // software pending: platform set wins over a software clear in the same cycle
   wire sup_software_pending_nxt = (SOFT_SET_I || (wr_ip ? wdat16[STCSR_SSI_BIT] : sup_software_pending_r)) && HAS_SSI;
   // overflow pending: any overflow flag sets, software may write it
   wire cof_nxt  = ((|EVT_OVF_I) || (wr_ip ? wdat16[STCSR_COF_BIT] : cof_r)) && HAS_COF;
   // enables keep only implemented positions so software can probe them
   wire [STCSR_STD_BITS-1:0] ie_nxt = wr_ie ? (wdat16 & IMPL_MASK) : ie_r;

   // counter enable: unimplemented bits hard-wired zero
   wire [STCSR_CEN_W-1:0] cen_nxt = (CSR_WE_I && sel_cen) ? (CSR_WDATA_I[STCSR_CEN_W-1:0] & CEN_IMPL) : cen_r;

   // exception pc: bit 0 never stored; trap entry has priority over software write
   wire [XLEN-1:0] epc_in  = TRAP_I.valid ? TRAP_I.pc[XLEN-1:0] : CSR_WDATA_I;
   wire            epc_we  = TRAP_I.valid || (CSR_WE_I && sel_epc);
   wire [XLEN-1:0] epc_nxt = epc_we ? {epc_in[XLEN-1:1], 1'b0} : epc_r;
   // bit 1 is masked on every read, including the return path, but kept stored
   wire            mask_b1 = ALIGN_32 || (ALIGN_SW && ALIGN32_NOW_I);
   wire [XLEN-1:0] epc_rd  = {epc_r[XLEN-1:2], epc_r[1] && !mask_b1, 1'b0};

   // cause: trap entry writes flag and code; software may also write
   wire                    cau_we    = TRAP_I.valid || (CSR_WE_I && sel_cau);
   wire                    cau_i_nxt = !cau_we ? cause_irq_r :
                                       TRAP_I.valid ? TRAP_I.is_irq : CSR_WDATA_I[XLEN-1];
   wire [STCSR_CODE_W-1:0] cau_c_nxt = !cau_we ? cause_code_r :
                                       TRAP_I.valid ? TRAP_I.code : CSR_WDATA_I[STCSR_CODE_W-1:0];

   // registers; all control state has a reset value
   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         ie_r         <= '0;
         sup_software_pending_r       <= 1'b0;
         cof_r        <= 1'b0;
         cen_r        <= STCSR_CEN_RST;
         scr_r        <= STCSR_WORD_RST[XLEN-1:0];
         epc_r        <= STCSR_WORD_RST[XLEN-1:0];
         cause_irq_r  <= 1'b0;
         cause_code_r <= '0;
         rt_due_r     <= 1'b0;
      end else begin
         ie_r         <= ie_nxt;
         sup_software_pending_r       <= sup_software_pending_nxt;
         cof_r        <= cof_nxt;
         cen_r        <= cen_nxt;
         scr_r        <= (CSR_WE_I && sel_scr) ? CSR_WDATA_I : scr_r;
         epc_r        <= epc_nxt;
         cause_irq_r  <= cau_i_nxt;
         cause_code_r <= cau_c_nxt;
         rt_due_r     <= rt_due_nxt;
      end
   end

   // machine-level view shares the same storage, so both names see one field
   assign M_IP_O = ip_view;
   assign M_IE_O = ie_r;

   // read mux; cause i sits at bit i of both pending and enable
   wire [XLEN-1:0] rd_ip  = XLEN'(ip_view);
   wire [XLEN-1:0] rd_ie  = XLEN'(ie_r);
   wire [XLEN-1:0] rd_cau = {cause_irq_r, {(XLEN-1-STCSR_CODE_W){1'b0}}, cause_code_r};
   assign CSR_RDATA_O = sel_ip  ? rd_ip :
                        sel_ie  ? rd_ie :
                        sel_cen ? XLEN'(cen_r) :
                        sel_scr ? scr_r :
                        sel_epc ? epc_rd :
                        sel_cau ? rd_cau : '0;
   assign CSR_HIT_O   = sel_ip || sel_ie || sel_cen || sel_scr || sel_epc || sel_cau;
   assign EPC_RET_O   = epc_rd;
   assign RT_DUE_O    = rt_due_r;

   // interrupt selection: ready set is pending and enabled, gated by mode
   wire [STCSR_STD_BITS-1:0] ready = ip_view & ie_r;
   wire mode_ok = USER_MODE_I || (SUP_MODE_I && SUP_GIE_I);
   assign IRQ_TAKE_O = mode_ok && (|ready);
   // fixed priority: external, software, timer, counter overflow
   assign IRQ_CODE_O = ready[STCSR_SEI_BIT] ? STCSR_CODE_W'(STCSR_SEI_BIT) :
                       ready[STCSR_SSI_BIT] ? STCSR_CODE_W'(STCSR_SSI_BIT) :
                       ready[STCSR_STI_BIT] ? STCSR_CODE_W'(STCSR_STI_BIT) :
                       ready[STCSR_COF_BIT] ? STCSR_CODE_W'(STCSR_COF_BIT) : '0;

   // user counter reads need both supervisor and machine enable bits
   wire cnt_ok = cen_r[CNT_REQ_I.counter] && M_CEN_I[CNT_REQ_I.counter];
   assign CNT_ILLEGAL_O = CNT_REQ_I.valid && CNT_REQ_I.user_mode && !cnt_ok;

   // checks; all run on the one clock and sleep during reset

   // external pending follows the platform only
   a_ext_readonly: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      M_IP_O[STCSR_SEI_BIT] == (HAS_SEI && EXT_IRQ_I))
      else $error("external pending not from platform");

   // timer pending follows the platform or the compare match only
   a_tim_readonly: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      M_IP_O[STCSR_STI_BIT] == (HAS_STI && (TIMER_IRQ_I || RT_DUE_O)))
      else $error("timer pending not from platform");

   // a platform set is never lost, even against a clear
   a_soft_set_wins: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      SOFT_SET_I && HAS_SSI |=> M_IP_O[STCSR_SSI_BIT])
      else $error("software pending set lost");

   // a software zero clears the software pending bit
   a_soft_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      wr_ip && !wdat16[STCSR_SSI_BIT] && !SOFT_SET_I |=> !M_IP_O[STCSR_SSI_BIT])
      else $error("software pending not cleared");

   // any overflow flag sets the overflow pending bit
   a_ovf_sets: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      (|EVT_OVF_I) && HAS_COF |=> M_IP_O[STCSR_COF_BIT])
      else $error("overflow pending not set");

   // overflow pending stays writable to software
   a_ovf_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      wr_ip && !wdat16[STCSR_COF_BIT] && !(|EVT_OVF_I) |=> !M_IP_O[STCSR_COF_BIT])
      else $error("overflow pending not cleared");

   // enables never hold an unimplemented position
   a_ie_legal: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      (ie_r & ~IMPL_MASK) == '0)
      else $error("enable holds unimplemented bit");

   // all ones written reads back as the implemented set
   a_ie_probe: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      wr_ie && (&wdat16) |=> ie_r == IMPL_MASK)
      else $error("enable probe wrong");

   // machine positions never show through
   a_mach_zero: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !M_IP_O[STCSR_MSI_BIT] && !M_IP_O[STCSR_MTI_BIT] && !M_IP_O[STCSR_MEI_BIT] &&
      !M_IE_O[STCSR_MSI_BIT] && !M_IE_O[STCSR_MTI_BIT] && !M_IE_O[STCSR_MEI_BIT])
      else $error("machine position visible");

   // priority ladder, one step per check
   a_prio_ext: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      ready[STCSR_SEI_BIT] |-> IRQ_CODE_O == STCSR_CODE_W'(STCSR_SEI_BIT))
      else $error("external not first");
   a_prio_soft: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !ready[STCSR_SEI_BIT] && ready[STCSR_SSI_BIT] |-> IRQ_CODE_O == STCSR_CODE_W'(STCSR_SSI_BIT))
      else $error("software before timer broken");
   a_prio_tim: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !ready[STCSR_SEI_BIT] && !ready[STCSR_SSI_BIT] && ready[STCSR_STI_BIT]
      |-> IRQ_CODE_O == STCSR_CODE_W'(STCSR_STI_BIT))
      else $error("timer before overflow broken");
   a_prio_cof: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      ready == (STCSR_STD_BITS'(1) << STCSR_COF_BIT) |-> IRQ_CODE_O == STCSR_CODE_W'(STCSR_COF_BIT))
      else $error("overflow alone not chosen");

   // a reached compare raises the due flag one cycle later
   a_rt_due: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      RT_COUNT_I >= RT_COMPARE_I |=> RT_DUE_O)
      else $error("timer compare missed");

   // counter enables keep only implemented bits
   a_cen_legal: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      (cen_r & ~CEN_IMPL) == '0)
      else $error("counter enable holds hard-wired bit");

   // the machine bits play no part in what the write stores
   a_cen_write: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      CSR_WE_I && sel_cen |=> cen_r == ($past(CSR_WDATA_I[STCSR_CEN_W-1:0]) & CEN_IMPL))
      else $error("counter enable write lost");

   // a missing machine bit always traps a user read
   a_cnt_trap: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      CNT_REQ_I.valid && CNT_REQ_I.user_mode && !M_CEN_I[CNT_REQ_I.counter] |-> CNT_ILLEGAL_O)
      else $error("counter read not trapped");

   // both bits set lets a user read through
   a_cnt_allow: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      cen_r[CNT_REQ_I.counter] && M_CEN_I[CNT_REQ_I.counter] |-> !CNT_ILLEGAL_O)
      else $error("permitted counter read trapped");

   // scratch stores the whole word as written
   a_scr_write: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      CSR_WE_I && sel_scr |=> scr_r == $past(CSR_WDATA_I))
      else $error("scratch write lost");

   // pc bit 0 never leaves the block, bit 1 only while it is not masked
   a_epc_bit0: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !EPC_RET_O[0] && (!mask_b1 || !EPC_RET_O[1]))
      else $error("pc low bits visible");

   // bit 1 stays writable while it is masked
   a_epc_keep_b1: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      CSR_WE_I && sel_epc && !TRAP_I.valid |=> epc_r[1] == $past(CSR_WDATA_I[1]))
      else $error("pc bit 1 not stored");

   // trap entry stores the pc
   a_epc_trap: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      TRAP_I.valid |=> epc_r == {$past(TRAP_I.pc[XLEN-1:1]), 1'b0})
      else $error("trap pc not stored");

   // nothing else moves the pc
   a_epc_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !TRAP_I.valid && !(CSR_WE_I && sel_epc) |=> $stable(epc_r))
      else $error("pc written spuriously");

   // trap entry stores flag and code
   a_cause_trap: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      TRAP_I.valid |=> cause_irq_r == $past(TRAP_I.is_irq) && cause_code_r == $past(TRAP_I.code))
      else $error("cause not written on trap");

   // nothing else moves the cause
   a_cause_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !TRAP_I.valid && !(CSR_WE_I && sel_cau) |=> $stable(cause_irq_r) && $stable(cause_code_r))
      else $error("cause written spuriously");

   // an unmapped number reads as zero
   a_unmapped: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !CSR_HIT_O |-> CSR_RDATA_O == '0)
      else $error("unmapped number returns data");

   // take only with a ready cause and a mode that allows it
   a_irq_mode: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      IRQ_TAKE_O |-> mode_ok && (|(M_IP_O & M_IE_O)))
      else $error("interrupt taken when not allowed");

   // main scenarios
   c_ext_taken:  cover property (@(posedge CLK_I) disable iff (!NRST_I) IRQ_TAKE_O && ready[STCSR_SEI_BIT]);
   c_two_ready:  cover property (@(posedge CLK_I) disable iff (!NRST_I) ready[STCSR_SSI_BIT] && ready[STCSR_STI_BIT]);
   c_cnt_trap:   cover property (@(posedge CLK_I) disable iff (!NRST_I) CNT_ILLEGAL_O);
   c_trap_entry: cover property (@(posedge CLK_I) disable iff (!NRST_I) TRAP_I.valid && TRAP_I.is_irq);
   c_epc_masked: cover property (@(posedge CLK_I) disable iff (!NRST_I) mask_b1 && epc_r[1]);
endmodule // stcsr_top
`default_nettype wire

// ---- tb/stcsr_plat.sv ----
// platform interrupt controller model driving the hart's pending sources
`timescale 1ns/1ps
`default_nettype none
module stcsr_plat #(
   parameter int N_EVT = 29
) (
   // clock
   input  wire logic             clk_i,
   // commands from the bench
   input  wire logic             ext_on_i,
   input  wire logic             tim_on_i,
   input  wire logic             ipi_i,
   input  wire logic             ovf_on_i,
   // sources toward the hart
   output var  logic             ext_irq_o,
   output var  logic             timer_irq_o,
   output var  logic             soft_set_o,
   output var  logic [N_EVT-1:0] evt_ovf_o
);
   // quiet sources from time zero, so the hart never sees an unknown request
   initial {ext_irq_o, timer_irq_o, soft_set_o, evt_ovf_o} = '0;
   // one register stage, like a real controller; only this model sets or clears the levels
   always @(posedge clk_i) begin
      ext_irq_o   <= ext_on_i;
      timer_irq_o <= tim_on_i;
      soft_set_o  <= ipi_i;
      evt_ovf_o   <= ovf_on_i ? {1'b1, {(N_EVT-1){1'b0}}} : '0;    // top flag, boundary case
   end
endmodule // stcsr_plat
`default_nettype wire

// ---- tb/stcsr_top_bench.sv ----
// self-checking bench of the supervisor trap control registers
`timescale 1ns/1ps
`default_nettype none
module stcsr_top_bench;
   import stcsr_pkg::*;
   // design-facing signals and bench state
   logic           clk, nrst, we, ext_on, tim_on, ipi, ovf_on, sup, usr, gie, a32, take, hit, ill, due;
   logic           ext_irq, tim_irq, soft_set;
   logic [28:0]    evt;
   logic [11:0]    num;
   logic [63:0]    wd, rd, rt_cnt, rt_cmp, epc_ret, r;
   logic [31:0]    mcen;
   logic [4:0]     code;
   logic [15:0]    mip, mie;
   logic [3:0]     m;
   stcsr_trap_t    trap;
   stcsr_cnt_req_t creq;
   int             n_mismatch, total_checks, cyc, seed;
   logic [11:0]    regs [6] = '{STCSR_IE_NUM, STCSR_CEN_NUM, STCSR_SCR_NUM, STCSR_EPC_NUM, STCSR_CAU_NUM, STCSR_IP_NUM};

   stcsr_top dut_u (.CLK_I(clk), .NRST_I(nrst), .CSR_WE_I(we), .CSR_NUM_I(num), .CSR_WDATA_I(wd),
      .CSR_RDATA_O(rd), .CSR_HIT_O(hit), .EXT_IRQ_I(ext_irq), .TIMER_IRQ_I(tim_irq), .SOFT_SET_I(soft_set),
      .EVT_OVF_I(evt), .RT_COUNT_I(rt_cnt), .RT_COMPARE_I(rt_cmp), .RT_DUE_O(due), .SUP_MODE_I(sup),
      .USER_MODE_I(usr), .SUP_GIE_I(gie), .ALIGN32_NOW_I(a32), .TRAP_I(trap), .CNT_REQ_I(creq),
      .M_CEN_I(mcen), .CNT_ILLEGAL_O(ill), .IRQ_TAKE_O(take), .IRQ_CODE_O(code), .EPC_RET_O(epc_ret),
      .M_IP_O(mip), .M_IE_O(mie));
   stcsr_plat plat_u (.clk_i(clk), .ext_on_i(ext_on), .tim_on_i(tim_on), .ipi_i(ipi), .ovf_on_i(ovf_on),
      .ext_irq_o(ext_irq), .timer_irq_o(tim_irq), .soft_set_o(soft_set), .evt_ovf_o(evt));

   // expected winner; v is {overflow, timer, software, external}
   function automatic logic [4:0] prio(input logic [3:0] v);
      return v[0] ? 5'h09 : v[1] ? 5'h01 : v[2] ? 5'h05 : 5'h0d;
   endfunction
   // expected pending word for the same encoding
   function automatic logic [63:0] pend(input logic [3:0] v);
      return {50'h0, v[3], 3'h0, v[0], 3'h0, v[2], 3'h0, v[1], 1'b0};
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one write, strobe held across exactly one sampling edge
   task automatic wr(input logic [11:0] n, input logic [63:0] d);
      @(posedge clk) #1 we = 1'b1;
      num = n;
      wd = d;
      @(posedge clk) #1 we = 1'b0;
   endtask
   // read is combinational, so sample midway between rising edges
   task automatic rdc(input logic [11:0] n, input logic [63:0] exp);
      @(posedge clk) #1 num = n;
      #1 chk(rd, exp);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // free-running 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end

   // main sequence
   initial begin
      seed = 32'h1d4d8bcd;
      {nrst, we, ext_on, tim_on, ipi, ovf_on, sup, gie, a32, usr} = 10'h001;
      {num, wd, rt_cnt, rt_cmp, mcen} = {STCSR_IE_NUM, 64'h0, 64'h0, 64'hffff_ffff_ffff_ffff, 32'h0};
      trap = '0;
      creq = '0;
      repeat (4) @(posedge clk);
      #1 nrst = 1'b1;
      foreach (regs[i]) begin
         rdc(regs[i], 64'h0);
         chk(hit, 1'b1);
      end
      rdc(12'h105, 64'h0);
      chk(hit, 1'b0);
      wr(STCSR_IE_NUM, '1);
      rdc(STCSR_IE_NUM, 64'h2222);
      chk(mie, 16'h2222);
      wr(STCSR_IP_NUM, '1);
      rdc(STCSR_IP_NUM, 64'h2002);
      wr(STCSR_IP_NUM, '0);
      rdc(STCSR_IP_NUM, 64'h0);
      // every pending combination first, then random ones, alternating the allowed modes
      for (int i = 0; i < 24; i++) begin
         m = (i < 16) ? i[3:0] : 4'($random(seed));
         {usr, sup, gie} = i[0] ? 3'b011 : 3'b100;
         @(posedge clk) #1 {ovf_on, tim_on, ext_on, ipi} = {m[3], m[2], m[0], m[1]};
         @(posedge clk) #1 ipi = 1'b0;
         repeat (2) @(posedge clk);
         rdc(STCSR_IP_NUM, pend(m));
         chk(mip, pend(m));
         chk(take, |m);
         if (|m) chk(code, prio(m));
         {usr, sup, gie} = 3'b010;
         #1 chk(take, 1'b0);
         {ovf_on, tim_on, ext_on} = 3'b000;
         repeat (2) @(posedge clk);
         wr(STCSR_IP_NUM, '0);
      end
      rt_cnt = 64'h5;
      rt_cmp = 64'h5;
      repeat (2) @(posedge clk);
      rdc(STCSR_IP_NUM, 64'h20);
      rt_cmp = 64'h6;
      repeat (2) @(posedge clk);
      #1 chk(due, 1'b0);
      // counter enables, scratch, exception pc and trap entry with random words
      for (int i = 0; i < 20; i++) begin
         r = {$random(seed), $random(seed)};
         wr(STCSR_CEN_NUM, r);
         rdc(STCSR_CEN_NUM, {32'h0, r[31:0]});
         mcen = $random(seed);
         creq = '{1'b1, 5'(i), i[0]};
         #1 chk(ill, i[0] & ~(r[i] & mcen[i]));
         wr(STCSR_SCR_NUM, r);
         rdc(STCSR_SCR_NUM, r);
         a32 = i[1];
         wr(STCSR_EPC_NUM, r);
         rdc(STCSR_EPC_NUM, r & ~64'(a32 ? 3 : 1));
         chk(epc_ret, r & ~64'(a32 ? 3 : 1));
         a32 = 1'b0;
         rdc(STCSR_EPC_NUM, r & ~64'h1);
         @(posedge clk) #1 trap = '{1'b1, i[2], 5'($random(seed)), ~r};
         @(posedge clk) #1 trap.valid = 1'b0;
         rdc(STCSR_EPC_NUM, ~r & ~64'h1);
         rdc(STCSR_CAU_NUM, {i[2], 58'h0, trap.code});
      end
      end_sim();
   end
endmodule // stcsr_top_bench
`default_nettype wire
